// [cfgmem_partner.sv]
// memory side of the data pin
module cfgmem_partner (input wire cfgmem_data_io_o, cfgmem_data_io_oe,
   output wire cfgmem_data_io_i);
   timeunit 1ns / 100ps;
   assign cfgmem_data_io_i = cfgmem_data_io_oe ?
      cfgmem_data_io_o : 1'h1;
endmodule

// [reset_and_power_state_pins.v]
// reset generator, power-enable and oscillator output, config-memory pin
// release for a dual channel usb serial device.
// assumes power_good comes from a supply comparator and osc_stable from the
// oscillator cell; usb_configured and usb_suspend come from usb core logic.
// the cfgmem pad enables are active high: high while this block drives.
// usb_bus_reset is wired in but deliberately reaches no output.
//
// Operation
// - after supply is good and clock runs, reset_out_n holds low 5.6 ms.
// - while ext_reset_n is low, reset_out_n is driven low.
// - a usb bus reset never affects reset_out_n.
// - power_enable_n goes low only once the usb host has configured us.
// - during usb suspend power_enable_n is driven high.
// - the reference clock is a 6 MHz crystal or external clock.
// - osc_out stops toggling during usb suspend.
// - cfgmem_select is high impedance while the device is in reset.
// - cfgmem_clock is undriven in reset and driven at all other times.
// - cfgmem_data_io is tri-stated during reset.

`include "rst_pwr_defines.vh"

module reset_and_power_state_pins #(
   parameter HOLD_CYCLES = `RST_HOLD_CYCLES
) (
   input wire core_clk,
   input wire nrst,
   input wire power_good,
   input wire osc_stable,
   input wire ext_reset_n,
   input wire usb_bus_reset,
   input wire usb_configured,
   input wire usb_suspend,
   input wire cfgmem_select_int,
   input wire cfgmem_clock_int,
   input wire cfgmem_data_int,
   input wire cfgmem_data_oe_int,
   input wire cfgmem_data_io_i,
   output reg reset_out_n,
   output reg device_reset_n,
   output reg power_enable_n,
   output reg osc_out,
   output reg cfgmem_select_o,
   output reg cfgmem_select_oe,
   output reg cfgmem_clock_o,
   output reg cfgmem_clock_oe,
   output reg cfgmem_data_io_o,
   output reg cfgmem_data_io_oe,
   output reg cfgmem_data_in
);

   // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
   localparam N_SYNC = 4;
   // ext_reset_n and the pulled-up data pin idle high, supply flags low
   localparam [N_SYNC-1:0] SYNC_IDLE = 4'hc;
   wire [N_SYNC-1:0] pin_raw;
   wire [N_SYNC-1:0] pin_flt;
   wire pg_q;
   wire os_q;
   wire er_q;
   wire di_q;

   assign pin_raw = {cfgmem_data_io_i, ext_reset_n, osc_stable, power_good};
   assign pg_q = pin_flt[0];
   assign os_q = pin_flt[1];
   assign er_q = pin_flt[2];
   assign di_q = pin_flt[3];

   genvar gi;
   generate
      for (gi = 0; gi < N_SYNC; gi = gi + 1) begin : g_sync
         reg [2:0] stg_q;
         reg flt_q;
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               stg_q <= {3{SYNC_IDLE[gi]}};
               flt_q <= SYNC_IDLE[gi];
            end else begin
               stg_q <= {stg_q[1:0], pin_raw[gi]};
               // a single-cycle glitch never reaches the filtered level
               if (stg_q[1] == stg_q[2])
                  flt_q <= stg_q[2];
            end
         end
         assign pin_flt[gi] = flt_q;
      end
   endgenerate

   // hold sequencer
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`RST_CNT_W-1:0] cnt_q;
   reg [`RST_CNT_W-1:0] cnt_d;
   wire supply_ok;
   wire hold_done;

   // last count of the hold, cut to the counter width on purpose
   localparam [31:0] HOLD_LAST = HOLD_CYCLES - 1;

   assign supply_ok = pg_q & os_q;
   // counter stays on the last count until the supply drops again
   assign hold_done = (cnt_q == HOLD_LAST[`RST_CNT_W-1:0]);

   // usb_bus_reset deliberately takes no part in the sequence
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         `ST_POR: begin
            cnt_d = {`RST_CNT_W{1'b0}};
            if (supply_ok)
               state_d = `ST_HOLD;
         end
         `ST_HOLD: begin
            if (!supply_ok) begin
               state_d = `ST_POR;
            end else if (hold_done) begin
               state_d = `ST_RUN;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         `ST_RUN: begin
            if (!supply_ok)
               state_d = `ST_POR;
         end
         default: begin
            state_d = `ST_POR;
         end
      endcase
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= `ST_POR;
         cnt_q <= {`RST_CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // next state, not current, so the pins follow on the same edge;
   // ext reset also releases the memory pins, as a device reset does
   wire in_reset;
   wire pwr_off;
   assign in_reset = (state_d != `ST_RUN) | ~er_q;
   assign pwr_off = in_reset | ~usb_configured | usb_suspend;

   // reference clock output divider
   localparam [31:0] OSC_LAST = `OSC_HALF_DIV - 1;
   reg [`OSC_DIV_W-1:0] div_q;
   wire osc_tick;
   assign osc_tick = (div_q == OSC_LAST[`OSC_DIV_W-1:0]);

   // reset pins: usb_bus_reset has no path here
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reset_out_n <= 1'b0;
         device_reset_n <= 1'b0;
      end else begin
         reset_out_n <= ~in_reset;
         device_reset_n <= ~in_reset;
      end
   end

   // power enable: low only when configured, awake and out of reset
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         power_enable_n <= 1'b1;
      end else begin
         power_enable_n <= pwr_off;
      end
   end

   // stand-in for the 6 MHz cell, held still in suspend
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= {`OSC_DIV_W{1'b0}};
         osc_out <= 1'b0;
      end else if (usb_suspend) begin
         div_q <= {`OSC_DIV_W{1'b0}};
      end else if (osc_tick) begin
         div_q <= {`OSC_DIV_W{1'b0}};
         osc_out <= ~osc_out;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // config-memory pins: released in reset, memory logic owns them after
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfgmem_select_o <= 1'b0;
         cfgmem_select_oe <= 1'b0;
         cfgmem_clock_o <= 1'b0;
         cfgmem_clock_oe <= 1'b0;
         cfgmem_data_io_o <= 1'b0;
         cfgmem_data_io_oe <= 1'b0;
      end else begin
         cfgmem_select_o <= cfgmem_select_int;
         cfgmem_select_oe <= ~in_reset;
         cfgmem_clock_o <= cfgmem_clock_int;
         cfgmem_clock_oe <= ~in_reset;
         cfgmem_data_io_o <= cfgmem_data_int;
         cfgmem_data_io_oe <= ~in_reset & cfgmem_data_oe_int;
      end
   end

   // data pin level through the synchroniser; pull-up level in reset
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfgmem_data_in <= 1'b1;
      end else begin
         cfgmem_data_in <= di_q;
      end
   end

endmodule

// [reset_and_power_state_pins_tb.sv]
// bench for the reset pin block; inputs move on falling edges
module reset_and_power_state_pins_tb;
   timeunit 1ns / 100ps;
   logic core_clk = 0, nrst = 0, power_good = 1, osc_stable = 1;
   logic ext_reset_n = 1, usb_bus_reset = 1, usb_configured = 0;
   logic usb_suspend = 0, cfgmem_select_int = 1, cfgmem_clock_int = 1;
   logic cfgmem_data_int = 0, cfgmem_data_oe_int = 1;
   wire reset_out_n, device_reset_n, power_enable_n, osc_out;
   wire cfgmem_select_o, cfgmem_select_oe, cfgmem_clock_o, cfgmem_clock_oe;
   wire cfgmem_data_io_o, cfgmem_data_io_oe, cfgmem_data_in, cfgmem_data_io_i;
   int n_errors = 0, tests_run = 0;
   reset_and_power_state_pins #(.HOLD_CYCLES(20)) i_dut (.*);
   cfgmem_partner i_mem (.*);
   initial forever #12.5 core_clk = ~core_clk;
   task summarize;
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(string s, logic e, logic g);
      tests_run++;
      if (g !== e) n_errors++;
      if (g !== e) $display("BAD %s exp %b got %b", s, e, g);
   endtask
   task cyc(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task t_start;
      cyc(20);
      chk("sel_oe", 0, cfgmem_select_oe);
      chk("clk_oe", 0, cfgmem_clock_oe);
      chk("data_oe", 0, cfgmem_data_io_oe);
      chk("pwr_rst", 1, power_enable_n);
      nrst = 1;
      cyc(24);
      chk("held", 0, reset_out_n);
      chk("dev_held", 0, device_reset_n);
      chk("pin_up", 1, cfgmem_data_in);
      cyc(1);
      chk("free", 1, reset_out_n);
      chk("dev_free", 1, device_reset_n);
      chk("sel_oe_on", 1, cfgmem_select_oe);
      chk("clk_oe_on", 1, cfgmem_clock_oe);
      chk("data_oe_on", 1, cfgmem_data_io_oe);
      chk("sel_o", 1, cfgmem_select_o);
      chk("clk_o", 1, cfgmem_clock_o);
      chk("data_o", 0, cfgmem_data_io_o);
      cyc(8);
      chk("pin_low", 0, cfgmem_data_in);
   endtask
   task t_run;
      logic o;
      usb_bus_reset = 0;
      cyc(3);
      chk("bus_rst", 1, reset_out_n);
      usb_bus_reset = 1;
      chk("pwr_idle", 1, power_enable_n);
      usb_configured = 1; // host has configured us; power_enable_n may now go low
      cyc(2);
      chk("pwr_on", 0, power_enable_n);
      o = osc_out;
      cyc(3);
      chk("osc_run", ~o, osc_out);
      usb_suspend = 1;
      cfgmem_data_oe_int = 0;
      o = osc_out;
      cyc(8);
      chk("pwr_off", 1, power_enable_n);
      chk("osc_stop", o, osc_out);
      usb_suspend = 0;
      cyc(2);
      chk("pwr_back", 0, power_enable_n);
      ext_reset_n = 0;
      cyc(6);
      chk("ext", 0, reset_out_n);
      chk("ext_sel", 0, cfgmem_select_oe);
      chk("ext_pwr", 1, power_enable_n);
      ext_reset_n = 1;
      cyc(6);
      chk("ext_free", 1, reset_out_n);
   endtask
   task t_supply;
      power_good = 0;
      cyc(6);
      chk("drop", 0, reset_out_n);
      power_good = 1;
      cyc(12);
      chk("rehold", 0, reset_out_n);
      cyc(20);
      chk("reup", 1, reset_out_n);
   endtask
   task t_rerst;
      nrst = 0;
      cyc(2);
      chk("rst_low", 0, reset_out_n);
      chk("rst_pwr", 1, power_enable_n);
      nrst = 1;
      cyc(26);
      chk("rst_up", 1, reset_out_n);
   endtask
   initial begin
      t_start;
      t_run;
      t_supply;
      t_rerst;
      summarize;
   end
   initial begin
      #50000 n_errors++;
      summarize;
   end
endmodule

// [rst_pwr_defines.vh]
// constants for the reset and power state pin block
// assumes core_clk at 40 MHz; times in microseconds unless named otherwise
`ifndef RST_PWR_DEFINES_VH
`define RST_PWR_DEFINES_VH

// core clock in kHz
`define CORE_CLK_KHZ 40000
// reset output hold after power-good and clock start, in microseconds
`define RST_HOLD_US 5600
// hold count in core clocks: 5600 us * 40 cycles/us
`define RST_HOLD_CYCLES ((`RST_HOLD_US * `CORE_CLK_KHZ) / 1000)
// hold counter width, enough for 224000
`define RST_CNT_W 18
// reference clock divider: 40 MHz / 6 MHz is not whole, nearest half period
`define OSC_HALF_DIV 3
`define OSC_DIV_W 2

// sequencer states
`define ST_POR 2'h0
`define ST_HOLD 2'h1
`define ST_RUN 2'h2

`endif

// [rst_pwr_monitor.sv]
// assertions on the reset pin block, bound onto its ports
module rst_pwr_monitor #(parameter HOLD_CYCLES = 224000) (
   input wire core_clk, nrst, ext_reset_n, power_good, usb_configured,
   input wire usb_suspend, reset_out_n, power_enable_n, osc_out,
   input wire cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_io_oe);
   timeunit 1ns / 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   int pg_cnt = 0;
   always @(posedge core_clk)
      if (!power_good) pg_cnt <= 0;
      else if (pg_cnt < HOLD_CYCLES) pg_cnt <= pg_cnt + 1;
   a_hold_span: assert property ($rose(reset_out_n) |->
      pg_cnt >= HOLD_CYCLES) else $error("hold");
   a_ext_low: assert property (!ext_reset_n [*6] |->
      !reset_out_n) else $error("ext");
   a_pwr_cfg: assert property (!power_enable_n |->
      $past(usb_configured)) else $error("pwr");
   a_susp_off: assert property (usb_suspend |=>
      power_enable_n) else $error("susp");
   a_osc_hold: assert property (usb_suspend [*3] |=>
      $stable(osc_out)) else $error("osc");
   a_sel_z: assert property (!reset_out_n |->
      !cfgmem_select_oe) else $error("sel");
   a_clk_drv: assert property (cfgmem_clock_oe == reset_out_n)
      else $error("clk");
   a_data_z: assert property (!reset_out_n |->
      !cfgmem_data_io_oe) else $error("data");
endmodule
bind reset_and_power_state_pins rst_pwr_monitor
   #(.HOLD_CYCLES(HOLD_CYCLES)) i_mon (.*);
